/* File: wake_pkg.sv */
// constants of the wake-up enable and configuration block
package wake_pkg;
  localparam logic [7:0] reg_status_low = 8'h00;
  localparam logic [7:0] reg_status_high = 8'h01;
  localparam logic [7:0] reg_enable_low = 8'h02;
  localparam logic [7:0] reg_enable_high = 8'h03;
  localparam logic [7:0] reg_configuration = 8'h04;
  localparam logic [7:0] reg_irq_status = 8'h08;
  localparam logic [7:0] reg_irq_mask = 8'h0C;
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [7:0] cfg_write_mask = 8'h0F;
  localparam int cfg_bank_lsb = 0;
  localparam int cfg_swap_bit = 2;
  localparam int cfg_pulse_bit = 3;
  localparam int ev_ring_one = 0;
  localparam int ev_ring_two = 1;
  localparam int ev_keyboard = 2;
  localparam int ev_mouse = 3;
  localparam int ev_infrared = 4;
  localparam int ev_gpio = 5;
  localparam int ev_software = 6;
  localparam int ev_module_irq = 7;
  localparam int irq_request_bit = 0;
  localparam int irq_pulse_bit = 1;
  localparam logic [1:0] irq_reset = 2'h0;
  localparam real clock_mhz = 250.0;
  localparam real pulse_time_ns = 100.0;
  localparam int pulse_cycles = int'(pulse_time_ns * clock_mhz / 1000.0);
  localparam logic [7:0] pulse_count_load = 8'(pulse_cycles);
  typedef enum logic [1:0] {
    bank_keyboard_mouse, bank_infrared, bank_routing, bank_standby_gpio
  } bank_type;
  typedef enum {pulse_idle, pulse_high, pulse_done} pulse_state_type;
endpackage : wake_pkg

/* File: wake_sticky_bank.sv */
// sticky write-one-to-clear event flags
`timescale 1ns/1ns
module wake_sticky_bank
  import wake_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] detect,
  input wire logic clear_write,
  input wire logic [7:0] clear_data,
  output logic [7:0] flags
);
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          flags[i] <= 1'b0;
        end else if (detect[i]) begin
          flags[i] <= 1'b1; // set wins over clear
        end else if (clear_write && clear_data[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : wake_sticky_bank

/* File: wake_event_enable_config.sv */
// wake event enables, configuration and power-up request
//
// Notes on behaviour
// - reset clears enables and configuration
// - enabled detected events drive request low
// - low enables: irq,sw,gpio,ir,mouse,kbd,ri2,ri1
// - high enables serve event inputs seven..zero
// - config bits 1-0 pick visible bank
// - config bit 2 swaps keyboard/mouse inputs
// - config bit 3 enables S3 button pulse
// - flags sticky, write one clears
`timescale 1ns/1ns
module wake_event_enable_config
  import wake_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] source_event,
  input wire logic [7:0] general_purpose_event_input,
  input wire logic keyboard_clock_in,
  input wire logic keyboard_data_in,
  input wire logic mouse_clock_in,
  input wire logic mouse_data_in,
  input wire logic sleep_s3,
  output logic keyboard_clock_wake,
  output logic keyboard_data_wake,
  output logic mouse_clock_wake,
  output logic mouse_data_wake,
  output logic [1:0] bank_select,
  output logic power_button_pulse,
  output logic power_up_request_n,
  output logic irq
);
  // ****************************************
  // register state
  // ****************************************
  logic [7:0] wake_event_enable_low;
  logic [7:0] wake_event_enable_high;
  logic [7:0] wake_configuration;
  logic [7:0] status_low;
  logic [7:0] status_high;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] pulse_count;
  pulse_state_type pulse_state;
  logic request_prev;
  logic pulse_event;

  // register index sits in address bits 9:2; the byte lane bits must be
  // zero so that an unaligned address never aliases onto a register
  function automatic logic hit(input logic [31:0] a, input logic [7:0] r);
    logic index_ok;
    logic lane_ok;
    logic upper_ok;
    index_ok = (a[9:2] == r);
    lane_ok = (a[1:0] == 2'h0);
    upper_ok = (a[31:10] == 22'h0);
    hit = index_ok && lane_ok && upper_ok;
  endfunction : hit

  logic access;
  logic wr;
  logic rd;
  logic known;
  logic [7:0] next_rdata;
  assign access = psel && penable && pready;
  assign wr = access && pwrite && pstrb[0];
  assign rd = access && !pwrite;
  assign known = hit(paddr, reg_status_low) || hit(paddr, reg_status_high)
    || hit(paddr, reg_enable_low) || hit(paddr, reg_enable_high)
    || hit(paddr, reg_configuration) || hit(paddr, reg_irq_status)
    || hit(paddr, reg_irq_mask);

  // ****************************************
  // sticky event flags
  // ****************************************
  wake_sticky_bank u_status_low (
    .clk(clk),
    .rst_n(rst_n),
    .detect(source_event),
    .clear_write(wr && hit(paddr, reg_status_low)),
    .clear_data(pwdata[7:0]),
    .flags(status_low)
  );
  wake_sticky_bank u_status_high (
    .clk(clk),
    .rst_n(rst_n),
    .detect(general_purpose_event_input),
    .clear_write(wr && hit(paddr, reg_status_high)),
    .clear_data(pwdata[7:0]),
    .flags(status_high)
  );

  // ****************************************
  // apb slave
  // ****************************************
  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && !known;
    end
  end

  always_comb begin
    next_rdata = byte_reset;
    if (hit(paddr, reg_status_low)) begin
      next_rdata = status_low;
    end else if (hit(paddr, reg_status_high)) begin
      next_rdata = status_high;
    end else if (hit(paddr, reg_enable_low)) begin
      next_rdata = wake_event_enable_low;
    end else if (hit(paddr, reg_enable_high)) begin
      next_rdata = wake_event_enable_high;
    end else if (hit(paddr, reg_configuration)) begin
      next_rdata = wake_configuration & cfg_write_mask;
    end else if (hit(paddr, reg_irq_status)) begin
      next_rdata = {6'h00, irq_status};
    end else if (hit(paddr, reg_irq_mask)) begin
      next_rdata = {6'h00, irq_mask};
    end
  end

  // data prepared a cycle early, valid with pready
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready && !pwrite) begin
      prdata <= {24'h000000, next_rdata};
    end else begin
      prdata <= 32'h00000000;
    end
  end

  // ****************************************
  // enable and configuration registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_event_enable_low <= byte_reset;
    end else if (wr && hit(paddr, reg_enable_low)) begin
      wake_event_enable_low <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_event_enable_high <= byte_reset;
    end else if (wr && hit(paddr, reg_enable_high)) begin
      wake_event_enable_high <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_configuration <= byte_reset;
    end else if (wr && hit(paddr, reg_configuration)) begin
      wake_configuration <= pwdata[7:0] & cfg_write_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bank_select <= 2'(bank_keyboard_mouse);
    end else begin
      bank_select <= wake_configuration[cfg_bank_lsb +: 2];
    end
  end

  // ****************************************
  // keyboard and mouse input swap
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      keyboard_clock_wake <= 1'b1;
      keyboard_data_wake <= 1'b1;
      mouse_clock_wake <= 1'b1;
      mouse_data_wake <= 1'b1;
    end else if (wake_configuration[cfg_swap_bit]) begin
      keyboard_clock_wake <= mouse_clock_in;
      keyboard_data_wake <= mouse_data_in;
      mouse_clock_wake <= keyboard_clock_in;
      mouse_data_wake <= keyboard_data_in;
    end else begin
      keyboard_clock_wake <= keyboard_clock_in;
      keyboard_data_wake <= keyboard_data_in;
      mouse_clock_wake <= mouse_clock_in;
      mouse_data_wake <= mouse_data_in;
    end
  end

  // ****************************************
  // power-up request
  // ****************************************
  logic request;
  assign request = |(status_low & wake_event_enable_low)
    || |(status_high & wake_event_enable_high);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_up_request_n <= 1'b1;
    end else begin
      power_up_request_n <= !request;
    end
  end

  // ****************************************
  // power button pulse in S3
  // ****************************************
  // fixed width pulse per rising request; a held request gives one pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      request_prev <= 1'b0;
    end else begin
      request_prev <= request;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_state <= pulse_idle;
      pulse_count <= byte_reset;
      power_button_pulse <= 1'b0;
    end else begin
      case (pulse_state)
        pulse_idle: begin
          if (request && !request_prev && sleep_s3
              && wake_configuration[cfg_pulse_bit]) begin
            pulse_state <= pulse_high;
            pulse_count <= pulse_count_load;
            power_button_pulse <= 1'b1;
          end
        end
        pulse_high: begin
          if (pulse_count == 8'h01) begin
            pulse_state <= pulse_done;
            power_button_pulse <= 1'b0;
          end else begin
            pulse_count <= pulse_count - 8'h01;
          end
        end
        pulse_done: begin
          pulse_state <= pulse_idle;
        end
        default: begin
          pulse_state <= pulse_idle;
          power_button_pulse <= 1'b0;
        end
      endcase
    end
  end
  assign pulse_event = (pulse_state == pulse_done);

  // ****************************************
  // interrupt status, cleared by read
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status <= irq_reset;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((b == irq_request_bit && request && !request_prev)
            || (b == irq_pulse_bit && pulse_event)) begin
          irq_status[b] <= 1'b1;
        end else if (rd && hit(paddr, reg_irq_status)) begin
          irq_status[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask <= irq_reset;
    end else if (wr && hit(paddr, reg_irq_mask)) begin
      irq_mask <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule : wake_event_enable_config

/* File: power_manager_model.sv */
// power sequencing model that sleeps in S3 and wakes on request
`timescale 1ns/1ns
module power_manager_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_up_request_n,
  input wire logic go_sleep,
  input wire logic [3:0] wake_delay,
  output logic sleep_s3
);
  logic [3:0] n;
  // leaves S3 only after the chosen delay, so it can wake slow or prompt
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_s3 <= 1'b0;
      n <= 4'h0;
    end else if (go_sleep) begin
      sleep_s3 <= 1'b1;
      n <= 4'h0;
    end else if (sleep_s3 && !power_up_request_n) begin
      n <= n + 4'h1;
      if (n == wake_delay) sleep_s3 <= 1'b0;
    end
  end
endmodule : power_manager_model

/* File: wake_event_enable_config_props.sv */
// checker of the wake enable block
`timescale 1ns/1ns
module wake_event_enable_config_props
  import wake_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [7:0] source_event,
  input wire logic [1:0] bank_select,
  input wire logic power_button_pulse,
  input wire logic power_up_request_n,
  input wire logic irq
);
  // ****
  // shadows of completed writes
  // ****
  localparam logic [31:0] addr_enable_low = {22'h0, reg_enable_low, 2'h0};
  localparam logic [31:0] addr_enable_high = {22'h0, reg_enable_high, 2'h0};
  localparam logic [31:0] addr_config = {22'h0, reg_configuration, 2'h0};
  logic [7:0] el, eh, cf, wide;
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      el <= 8'h00;
      eh <= 8'h00;
      cf <= 8'h00;
    end else if (wr) begin
      if (paddr == addr_enable_low) el <= pwdata[7:0];
      if (paddr == addr_enable_high) eh <= pwdata[7:0];
      // reserved bits are never stored
      if (paddr == addr_config) cf <= pwdata[7:0] & 8'h0F;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || !power_button_pulse) wide <= 8'h00;
    else wide <= wide + 8'h01;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_reset_clears: assert property (disable iff (1'b0)
    !rst_n |=> power_up_request_n && !irq && bank_select == 2'h0)
    else $error("outputs not cleared by reset");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_enable_read: assert property (
    pready && !pwrite && paddr == addr_enable_low |-> prdata == 32'(el))
    else $error("enable low read wrong");
  a_config_read: assert property (
    pready && !pwrite && paddr == addr_config |-> prdata == 32'(cf))
    else $error("configuration read wrong");
  a_request_raised: assert property (
    (|(source_event & el)) && !psel |-> ##[1:2] !power_up_request_n)
    else $error("enabled event gave no request");
  a_request_quiet: assert property (
    (el == 8'h00 && eh == 8'h00) [*2] |-> power_up_request_n)
    else $error("request with all enables clear");
  a_bank_follows: assert property (
    $past(rst_n) |-> bank_select == 2'($past(cf)))
    else $error("bank select wrong");
  a_pulse_width: assert property (
    $fell(power_button_pulse) |-> wide == 8'(pulse_cycles))
    else $error("button pulse width wrong");
  a_pulse_cause: assert property (
    $rose(power_button_pulse) |-> cf[3])
    else $error("button pulse while disabled");
  c_request: cover property ($fell(power_up_request_n));
  c_pulse: cover property ($rose(power_button_pulse));
  c_bank: cover property (bank_select == 2'h3);
endmodule : wake_event_enable_config_props
bind wake_event_enable_config wake_event_enable_config_props props_i (.*);

/* File: wake_event_enable_config_test.sv */
// bench of the wake enable block
`timescale 1ns/1ns
module wake_event_enable_config_test;
  import wake_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, go_sleep;
  logic keyboard_clock_in, keyboard_data_in, mouse_clock_in, mouse_data_in;
  logic keyboard_clock_wake, keyboard_data_wake, mouse_clock_wake, irq;
  logic mouse_data_wake, sleep_s3, power_button_pulse, power_up_request_n;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] source_event, general_purpose_event_input, a, s, b;
  logic [3:0] pstrb, wake_delay;
  logic [1:0] bank_select;
  int n_mismatch = 0;
  int num_checks = 0;
  int i, n;
  wake_event_enable_config dut (.*);
  power_manager_model pm (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****
  // bus tasks and checks
  // ****
  task automatic wrap_up;
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one idle cycle before setup, so psel never gets two values at one edge
  task automatic apb(logic w, logic [7:0] ad, logic [7:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, ad, 2'h0};
    pwdata <= 32'(d);
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(logic [7:0] ad, logic [7:0] e);
    apb(1'b0, ad, 8'h00);
    check("read data", rd, 32'(e));
  endtask : rdc
  task automatic wrr(logic [7:0] ad, logic [7:0] d, logic [7:0] e);
    apb(1'b1, ad, d);
    rdc(ad, e);
  endtask : wrr
  initial begin
    {rst_n, psel, penable, pwrite, go_sleep} = 5'h00;
    {paddr, pwdata, source_event, general_purpose_event_input} = 80'h0;
    {pstrb, wake_delay} = 8'hF1;
    {keyboard_clock_in, keyboard_data_in} = 2'h2;
    {mouse_clock_in, mouse_data_in} = 2'h1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 2; i < 5; i++) rdc(8'(i), 8'h00);
    wrr(reg_enable_low, 8'hA5, 8'hA5);
    wrr(reg_enable_high, 8'h5A, 8'h5A);
    wrr(reg_configuration, 8'hFF, 8'h0F);
    apb(1'b1, 8'h10, 8'h00);
    check("unmapped error", 32'(err), 32'h1);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, reg_configuration, 8'(i));
      repeat (2) @(posedge clk);
      check("bank", 32'(bank_select), 32'(i % 4));
      check("pairs", 32'({keyboard_clock_wake, keyboard_data_wake,
        mouse_clock_wake, mouse_data_wake}), i > 3 ? 32'h6 : 32'h9);
    end
    // each event first with only the others enabled, then alone
    for (i = 0; i < 16; i++) begin
      a = i < 8 ? reg_enable_low : reg_enable_high;
      s = i < 8 ? reg_status_low : reg_status_high;
      b = 8'h01 << (i % 8);
      apb(1'b1, a, ~b);
      if (i < 8) source_event <= b;
      else general_purpose_event_input <= b;
      @(posedge clk);
      {source_event, general_purpose_event_input} <= 16'h0;
      repeat (3) @(posedge clk);
      check("idle request", 32'(power_up_request_n), 32'h1);
      apb(1'b1, a, b);
      repeat (3) @(posedge clk);
      check("request", 32'(power_up_request_n), 32'h0);
      apb(1'b1, a, 8'h00);
      repeat (3) @(posedge clk);
      check("gated request", 32'(power_up_request_n), 32'h1);
      wrr(s, 8'h00, b);
      wrr(s, b, 8'h00);
      check("masked irq", 32'(irq), 32'h0);
    end
    wrr(reg_irq_mask, 8'h02, 8'h02);
    apb(1'b1, reg_enable_low, 8'h40);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, reg_configuration, i > 0 ? 8'h08 : 8'h00);
      wake_delay <= i > 0 ? 4'h8 : 4'h1;
      go_sleep <= 1'b1;
      @(posedge clk);
      go_sleep <= 1'b0;
      source_event <= 8'h40;
      @(posedge clk);
      source_event <= 8'h00;
      n = 0;
      repeat (100) begin
        @(posedge clk);
        n += power_button_pulse;
      end
      check("pulse width", n, i > 0 ? pulse_cycles : 0);
      check("irq", 32'(irq), 32'(i));
      wrr(reg_status_low, 8'h40, 8'h00);
    end
    rdc(reg_irq_status, 8'h03);
    repeat (2) @(posedge clk);
    check("irq cleared", 32'(irq), 32'h0);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 2; i < 5; i++) rdc(8'(i), 8'h00);
    wrap_up();
  end
endmodule : wake_event_enable_config_test
